// [include/scu_pkg.sv]
// Package of constants and types for the sensor user calibration block.
// Functional notes
// - Gyro offset registers: 16-bit two's complement, 0.01 dps/LSB, zero is none.
// - Each axis offset is added last, just before the output register loads.
// - Bias-null command loads each gyro offset with the negated gyro output.
// - Range code 001 gives gyro outputs 0.01 dps per LSB.
// - Decimation code 0x10 gives factor 65,536, about 80 s averaging.
// - 16-bit register written as two byte writes; device merges both bytes.
// - X accel offset: 16-bit two's complement, 1/1200 g per LSB.
// - Y and Z accel offsets use bits 13:0 only; bits 15:14 unused.
// - Accel offsets are added like gyro offsets, before output loading.
// - Misc control bit 6 enables point-of-percussion translation.
// - Hard-iron registers: 16-bit two's complement offset per magnetometer axis.
// - Soft-iron gain 100%/32767 per LSB; 0x7FFF doubles, 0x8000 zeroes.
// - Factory restore zeroes gyro/accel offsets and data, saves flash, restarts.
// - Global command bit 3 saves user corrections to flash.
`default_nettype none
package scu_pkg;
  localparam logic [6:0] GYRO_OFFSET_X = 7'h1a;
  localparam logic [6:0] GYRO_OFFSET_Y = 7'h1c;
  localparam logic [6:0] GYRO_OFFSET_Z = 7'h1e;
  localparam logic [6:0] ACCEL_OFFSET_X = 7'h20;
  localparam logic [6:0] ACCEL_OFFSET_Y = 7'h22;
  localparam logic [6:0] ACCEL_OFFSET_Z = 7'h24;
  localparam logic [6:0] MAG_HARD_IRON_X = 7'h26;
  localparam logic [6:0] MAG_HARD_IRON_Y = 7'h28;
  localparam logic [6:0] MAG_HARD_IRON_Z = 7'h2a;
  localparam logic [6:0] MAG_SOFT_IRON_X = 7'h2c;
  localparam logic [6:0] MAG_SOFT_IRON_Y = 7'h2e;
  localparam logic [6:0] MAG_SOFT_IRON_Z = 7'h30;
  localparam logic [6:0] MISC_CONTROL = 7'h34;
  localparam logic [6:0] SAMPLE_PERIOD_CTRL = 7'h36;
  localparam logic [6:0] SENSOR_FILTER_RANGE = 7'h38;
  localparam logic [6:0] GLOBAL_COMMAND = 7'h3e;
  localparam logic [6:0] RESULT_FIRST = 7'h04;
  localparam logic [6:0] RESULT_LAST = 7'h14;
  localparam logic [15:0] OFFSET_RESET = 16'h0000;
  localparam logic [15:0] SOFT_IRON_RESET = 16'h8000;
  localparam logic [15:0] MISC_RESET = 16'h0000;
  localparam logic [15:0] SAMPLE_PERIOD_RESET = 16'h0001;
  localparam logic [15:0] FILTER_RANGE_RESET = 16'h0402;
  localparam int CAL_COUNT = 12;
  localparam int SOFT_IRON_FIRST = 9;
  localparam int ACCEL_Y_INDEX = 4;
  localparam int ACCEL_Z_INDEX = 5;
  localparam int GYRO_ACCEL_COUNT = 6;
  localparam int RESULT_COUNT = 9;
  localparam int CMD_BIAS_NULL_BIT = 0;
  localparam int CMD_RESTORE_BIT = 1;
  localparam int CMD_FLASH_SAVE_BIT = 3;
  localparam int MISC_POP_BIT = 6;
  localparam int RANGE_LSB = 8;
  localparam int RANGE_MSB = 10;
  localparam int DECIM_LSB = 8;
  localparam int DECIM_MSB = 12;
  localparam int TAPS_MSB = 2;
  localparam int CLK_SEL_BIT = 0;
  localparam int ACCEL_YZ_MSB = 13;
  localparam logic signed [16:0] GAIN_UNITY = 17'sd32767;
  localparam logic [3:0] FRAME_LAST_BIT = 4'hf;
  typedef struct packed {
    logic [2:0][15:0] mag;
    logic [2:0][15:0] accel;
    logic [2:0][15:0] gyro;
  } scu_sensor_t;
  typedef struct packed {
    logic write;
    logic [6:0] addr;
    logic [7:0] data;
  } scu_frame_t;
endpackage
`default_nettype wire

// [src/scu_top.sv]
// Serial register port and user calibration datapath for the sensor outputs.
`default_nettype none
module scu_top (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic mosi_i,
  output logic miso_o,
  input wire logic sample_valid_i,
  input wire scu_pkg::scu_sensor_t sample_i,
  output scu_pkg::scu_sensor_t result_o,
  output logic result_valid_o,
  output logic [2:0] gyro_range_o,
  output logic [2:0] filter_taps_o,
  output logic [4:0] decim_code_o,
  output logic [31:0] decim_factor_o,
  output logic ext_clock_sel_o,
  output logic pop_enable_o,
  output logic flash_save_o,
  output logic factory_restore_o
);
  // Link side, clocked by the serial clock.
  logic [3:0] bit_cnt;
  logic [15:0] rx_shift;
  scu_pkg::scu_frame_t rx_frame;
  logic rx_toggle;
  logic [14:0] tx_shift;
  logic [15:0] tx_word;

  // Chip select clears the bit count so a broken frame never completes.
  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      bit_cnt <= 4'h0;
    end else begin
      bit_cnt <= bit_cnt + 4'h1;
    end
  end

  always_ff @(posedge sclk_i) begin
    rx_shift <= {rx_shift[14:0], mosi_i};
  end

  // The frame word holds steady until the next frame ends, long after the
  // system side has taken it.
  always_ff @(posedge sclk_i) begin
    if (bit_cnt == scu_pkg::FRAME_LAST_BIT) begin
      rx_frame <= {rx_shift[14:0], mosi_i};
    end
  end

  always_ff @(posedge sclk_i or posedge reset_i) begin
    if (reset_i) begin
      rx_toggle <= 1'b0;
    end else if (bit_cnt == scu_pkg::FRAME_LAST_BIT) begin
      rx_toggle <= ~rx_toggle;
    end
  end

  // Read data is loaded on the first falling edge of a frame; the answer
  // word is stable by then because the host leaves a gap between frames.
  always_ff @(negedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      miso_o <= 1'b0;
      tx_shift <= 15'h0000;
    end else if (bit_cnt == 4'h0) begin
      {miso_o, tx_shift} <= tx_word;
    end else begin
      {miso_o, tx_shift} <= {tx_shift, 1'b0};
    end
  end

  // System side.
  logic tog_s1;
  logic tog_s2;
  logic tog_s3;
  logic frame_evt;
  logic cal_hit;
  logic [3:0] cal_idx;
  logic res_hit;
  logic [3:0] res_idx;
  logic [6:0] cal_off;
  logic [6:0] res_off;
  logic [15:0] cal [scu_pkg::CAL_COUNT];
  logic [15:0] wr_val;
  logic [15:0] misc_ctrl;
  logic [15:0] smpl_ctrl;
  logic [15:0] range_ctrl;
  logic [8:0][15:0] res_words;
  logic wr_en;
  logic is_cmd;
  logic cmd_null;
  logic cmd_restore;
  logic cmd_save;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      tog_s1 <= 1'b0;
      tog_s2 <= 1'b0;
      tog_s3 <= 1'b0;
    end else begin
      tog_s1 <= rx_toggle;
      tog_s2 <= tog_s1;
      tog_s3 <= tog_s2;
    end
  end

  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic hi,
                                        input logic [7:0] data);
    merge = hi ? {data, old[7:0]} : {old[15:8], data};
  endfunction

  function automatic logic [15:0] sat16(input logic signed [33:0] v);
    if (v > 34'sd32767) begin
      sat16 = 16'h7fff;
    end else if (v < -34'sd32768) begin
      sat16 = 16'h8000;
    end else begin
      sat16 = v[15:0];
    end
  endfunction

  always_comb begin
    frame_evt = tog_s2 ^ tog_s3;
    wr_en = frame_evt & rx_frame.write;
    cal_off = rx_frame.addr - scu_pkg::GYRO_OFFSET_X;
    res_off = rx_frame.addr - scu_pkg::RESULT_FIRST;
    cal_hit = (rx_frame.addr >= scu_pkg::GYRO_OFFSET_X) &&
              (rx_frame.addr <= scu_pkg::MAG_SOFT_IRON_Z + 7'h01);
    res_hit = (rx_frame.addr >= scu_pkg::RESULT_FIRST) &&
              (rx_frame.addr <= scu_pkg::RESULT_LAST + 7'h01);
    cal_idx = cal_off[4:1];
    res_idx = res_off[4:1];
    wr_val = merge(cal[cal_idx], rx_frame.addr[0], rx_frame.data);
    if (cal_idx == 4'(scu_pkg::ACCEL_Y_INDEX) ||
        cal_idx == 4'(scu_pkg::ACCEL_Z_INDEX)) begin
      wr_val[15:14] = 2'b00;
    end
    is_cmd = wr_en && (rx_frame.addr == scu_pkg::GLOBAL_COMMAND);
    cmd_null = is_cmd && rx_frame.data[scu_pkg::CMD_BIAS_NULL_BIT];
    cmd_restore = is_cmd && rx_frame.data[scu_pkg::CMD_RESTORE_BIT];
    cmd_save = is_cmd && rx_frame.data[scu_pkg::CMD_FLASH_SAVE_BIT];
    res_words = {result_o.mag, result_o.accel, result_o.gyro};
  end

  // Correction registers. Restore outranks bias-null, which outranks a
  // plain byte write arriving in the same frame.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      for (int i = 0; i < scu_pkg::CAL_COUNT; i++) begin
        cal[i] <= (i >= scu_pkg::SOFT_IRON_FIRST) ?
                  scu_pkg::SOFT_IRON_RESET : scu_pkg::OFFSET_RESET;
      end
    end else if (cmd_restore) begin
      for (int i = 0; i < scu_pkg::GYRO_ACCEL_COUNT; i++) begin
        cal[i] <= scu_pkg::OFFSET_RESET;
      end
    end else if (cmd_null) begin
      for (int i = 0; i < 3; i++) begin
        cal[i] <= (result_o.gyro[i] == 16'h8000) ? 16'h7fff :
                  16'(-result_o.gyro[i]);
      end
    end else if (wr_en && cal_hit) begin
      cal[cal_idx] <= wr_val;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      misc_ctrl <= scu_pkg::MISC_RESET;
      smpl_ctrl <= scu_pkg::SAMPLE_PERIOD_RESET;
      range_ctrl <= scu_pkg::FILTER_RANGE_RESET;
    end else if (wr_en) begin
      if (rx_frame.addr[6:1] == scu_pkg::MISC_CONTROL[6:1]) begin
        misc_ctrl <= merge(misc_ctrl, rx_frame.addr[0], rx_frame.data);
      end
      if (rx_frame.addr[6:1] == scu_pkg::SAMPLE_PERIOD_CTRL[6:1]) begin
        smpl_ctrl <= merge(smpl_ctrl, rx_frame.addr[0], rx_frame.data);
      end
      if (rx_frame.addr[6:1] == scu_pkg::SENSOR_FILTER_RANGE[6:1]) begin
        range_ctrl <= merge(range_ctrl, rx_frame.addr[0], rx_frame.data);
      end
    end
  end

  // Read answer for the next frame; unmapped addresses answer zero.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      tx_word <= 16'h0000;
    end else if (frame_evt && !rx_frame.write) begin
      if (cal_hit) begin
        tx_word <= cal[cal_idx];
      end else if (res_hit) begin
        tx_word <= res_words[res_idx];
      end else if (rx_frame.addr[6:1] == scu_pkg::MISC_CONTROL[6:1]) begin
        tx_word <= misc_ctrl;
      end else if (rx_frame.addr[6:1] ==
                   scu_pkg::SAMPLE_PERIOD_CTRL[6:1]) begin
        tx_word <= smpl_ctrl;
      end else if (rx_frame.addr[6:1] ==
                   scu_pkg::SENSOR_FILTER_RANGE[6:1]) begin
        tx_word <= range_ctrl;
      end else begin
        tx_word <= 16'h0000;
      end
    end
  end

  // Control outputs towards the sampling and filter chain.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      gyro_range_o <= 3'h0;
      filter_taps_o <= 3'h0;
      decim_code_o <= 5'h00;
      decim_factor_o <= 32'h00000001;
      ext_clock_sel_o <= 1'b0;
      pop_enable_o <= 1'b0;
    end else begin
      gyro_range_o <= range_ctrl[scu_pkg::RANGE_MSB:scu_pkg::RANGE_LSB];
      filter_taps_o <= range_ctrl[scu_pkg::TAPS_MSB:0];
      decim_code_o <= smpl_ctrl[scu_pkg::DECIM_MSB:scu_pkg::DECIM_LSB];
      // factor is two to the code
      decim_factor_o <= 32'h00000001 <<
                        smpl_ctrl[scu_pkg::DECIM_MSB:scu_pkg::DECIM_LSB];
      ext_clock_sel_o <= ~smpl_ctrl[scu_pkg::CLK_SEL_BIT];
      pop_enable_o <= misc_ctrl[scu_pkg::MISC_POP_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      flash_save_o <= 1'b0;
      factory_restore_o <= 1'b0;
    end else begin
      flash_save_o <= cmd_save | cmd_null | cmd_restore;
      factory_restore_o <= cmd_restore;
    end
  end

  // Correction datapath. The multiply by a gain near one is exact before
  // the divide, trading area for no rounding drift on the magnetometers.
  logic signed [16:0] gyro_sum [3];
  logic signed [16:0] accel_sum [3];
  logic signed [16:0] mag_sum [3];
  logic signed [16:0] gain [3];
  logic signed [33:0] mag_prod [3];
  logic [15:0] accel_off [3];

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      // X full width, Y and Z sign from bit 13
      accel_off[i] = (i == 0) ? cal[3] :
        {{2{cal[3 + i][scu_pkg::ACCEL_YZ_MSB]}}, cal[3 + i][13:0]};
      gyro_sum[i] = $signed(sample_i.gyro[i]) + $signed(cal[i]);
      accel_sum[i] = $signed(sample_i.accel[i]) + $signed(accel_off[i]);
      mag_sum[i] = $signed(sample_i.mag[i]) + $signed(cal[6 + i]);
      gain[i] = scu_pkg::GAIN_UNITY + $signed(cal[9 + i]);
      if (gain[i] < 17'sd0) begin
        gain[i] = 17'sd0;
      end
      mag_prod[i] = (34'(mag_sum[i]) * 34'(gain[i])) /
                    34'(scu_pkg::GAIN_UNITY);
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i || cmd_restore) begin
      result_o <= '0;
      result_valid_o <= 1'b0;
    end else begin
      result_valid_o <= sample_valid_i;
      if (sample_valid_i) begin
        for (int i = 0; i < 3; i++) begin
          result_o.gyro[i] <= sat16(34'(gyro_sum[i]));
          result_o.accel[i] <= sat16(34'(accel_sum[i]));
          result_o.mag[i] <= sat16(mag_prod[i]);
        end
      end
    end
  end
endmodule
`default_nettype wire

// [sim/scu_checker.sv]
// Port assertions for the sensor user calibration block.
`default_nettype none
module scu_checker (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic cs_n_i,
  input wire logic miso_o,
  input wire logic sample_valid_i,
  input wire scu_pkg::scu_sensor_t result_o,
  input wire logic result_valid_o,
  input wire logic [4:0] decim_code_o,
  input wire logic [31:0] decim_factor_o,
  input wire logic pop_enable_o,
  input wire logic flash_save_o,
  input wire logic factory_restore_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  chk_valid_next: assert property (
    sample_valid_i |=> result_valid_o) else $error("valid missing");
  chk_valid_cause: assert property (
    result_valid_o |-> $past(sample_valid_i)) else $error("stray valid");
  // A one cycle lag of the factor behind the code is tolerated.
  chk_factor_code: assert property (
    $stable(decim_code_o) |-> decim_factor_o == 32'h1 << decim_code_o)
    else $error("decimation factor wrong");
  chk_result_hold: assert property (
    !sample_valid_i && !factory_restore_o |=>
    $stable(result_o) || factory_restore_o) else $error("result moved");
  chk_restore_clear: assert property (
    factory_restore_o |-> ##[0:1] result_o == '0)
    else $error("results not cleared");
  chk_restore_save: assert property (
    factory_restore_o |-> (flash_save_o || $past(flash_save_o))
    or (##1 flash_save_o)) else $error("restore without save");
  chk_save_pulse: assert property (
    flash_save_o |=> !flash_save_o) else $error("save pulse long");
  chk_restore_pulse: assert property (
    factory_restore_o |=> !factory_restore_o) else $error("restore long");
  chk_miso_idle: assert property (
    cs_n_i [*3] |-> !miso_o) else $error("serial out not idle");
  chk_pop_stable: assert property (
    cs_n_i [*8] |-> $stable(pop_enable_o)) else $error("pop moved");
  cover property (sample_valid_i);
  cover property (factory_restore_o);
  cover property (flash_save_o && !factory_restore_o);
endmodule
bind scu_top scu_checker u_chk (.clk_i(clk_i), .reset_i(reset_i),
  .cs_n_i(cs_n_i), .miso_o(miso_o), .sample_valid_i(sample_valid_i),
  .result_o(result_o), .result_valid_o(result_valid_o),
  .decim_code_o(decim_code_o), .decim_factor_o(decim_factor_o),
  .pop_enable_o(pop_enable_o), .flash_save_o(flash_save_o),
  .factory_restore_o(factory_restore_o));
`default_nettype wire

// [sim/scu_host.sv]
// Host processor model driving the serial register port.
`default_nettype none
module scu_host (
  output logic sclk_o,
  output logic cs_n_o,
  output logic mosi_o,
  input wire logic miso_i
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sclk_o = 1'b1;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // sixteen bit frame
  // The clock stands high between frames and data moves on falling edges.
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    #7 cs_n_o = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      #40 sclk_o = 1'b0;
      mosi_o = w[i];
      #40 r[i] = miso_i;
      sclk_o = 1'b1;
    end
    #40 cs_n_o = 1'b1;
    mosi_o = ~w[0];
    #120;
  endtask
  task automatic wr16(input logic [6:0] a, input logic [15:0] d);
    logic [15:0] r;
    xfer({1'b1, a | 7'h01, d[15:8]}, r);
    xfer({1'b1, a, d[7:0]}, r);
  endtask
  task automatic wr8(input logic [6:0] a, input logic [7:0] d);
    logic [15:0] r;
    xfer({1'b1, a, d}, r);
  endtask
  // The answer to a read comes back during the following frame.
  task automatic rd16(input logic [6:0] a, output logic [15:0] d);
    logic [15:0] r;
    xfer({1'b0, a, 8'h00}, r);
    xfer({1'b0, a, 8'h00}, d);
  endtask
endmodule
`default_nettype wire

// [sim/sensor_user_calibration_tb.sv]
// Self-checking bench for the sensor user calibration block.
`default_nettype none
module sensor_user_calibration_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic sample_valid_i = 1'b0;
  scu_pkg::scu_sensor_t sample_i = '0;
  scu_pkg::scu_sensor_t result_o;
  logic sclk, cs_n, mosi, miso_o, result_valid_o, pop_enable_o;
  logic ext_clock_sel_o, flash_save_o, factory_restore_o;
  logic [2:0] gyro_range_o, filter_taps_o;
  logic [4:0] decim_code_o;
  logic [31:0] decim_factor_o;
  logic [15:0] v;
  int fail_count = 0, tests_run = 0, cyc = 0, saves = 0, restores = 0;
  always #5 clk_i = ~clk_i;
  scu_top DUT (.clk_i(clk_i), .reset_i(reset_i), .sclk_i(sclk),
    .cs_n_i(cs_n), .mosi_i(mosi), .miso_o(miso_o),
    .sample_valid_i(sample_valid_i), .sample_i(sample_i),
    .result_o(result_o), .result_valid_o(result_valid_o),
    .gyro_range_o(gyro_range_o), .filter_taps_o(filter_taps_o),
    .decim_code_o(decim_code_o), .decim_factor_o(decim_factor_o),
    .ext_clock_sel_o(ext_clock_sel_o), .pop_enable_o(pop_enable_o),
    .flash_save_o(flash_save_o), .factory_restore_o(factory_restore_o));
  scu_host host (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi),
    .miso_i(miso_o));
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, e);
    tests_run++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rchk(input logic [6:0] a, input logic [15:0] e);
    host.rd16(a, v);
    chk($sformatf("register %h", a), {16'h0, v}, {16'h0, e});
  endtask
  task automatic send(input scu_pkg::scu_sensor_t s);
    @(posedge clk_i);
    sample_i <= s;
    sample_valid_i <= 1'b1;
    @(posedge clk_i);
    sample_valid_i <= 1'b0;
    #1 chk("result valid", 32'(result_valid_o), 32'h1);
    @(posedge clk_i);
    #1 chk("valid pulse", 32'(result_valid_o), 32'h0);
  endtask
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (flash_save_o === 1'b1) saves <= saves + 1;
    if (factory_restore_o === 1'b1) restores <= restores + 1;
  end
  // The ceiling is nearly four times the expected run.
  always @(posedge clk_i) begin
    if (cyc == 40000) begin
      fail_count++;
      test_done;
    end
  end
  initial begin
    scu_pkg::scu_sensor_t s;
    repeat (4) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1 chk("range", 32'(gyro_range_o), 32'h4);
    chk("taps", 32'(filter_taps_o), 32'h2);
    chk("factor", decim_factor_o, 32'h1);
    for (int i = 0; i < 12; i++) begin
      rchk(7'h1a + 7'(2 * i), i < 9 ? 16'h0000 : 16'h8000);
    end
    rchk(scu_pkg::SAMPLE_PERIOD_CTRL, 16'h0001);
    rchk(scu_pkg::SENSOR_FILTER_RANGE, 16'h0402);
    host.wr16(7'h50, 16'h1234);
    rchk(7'h50, 16'h0000);
    // negated bias estimate of ten counts
    host.wr16(scu_pkg::GYRO_OFFSET_X, -16'sd10);
    host.wr16(scu_pkg::GYRO_OFFSET_Z, 16'h0010);
    host.wr16(scu_pkg::ACCEL_OFFSET_X, 16'hfff4);
    host.wr16(scu_pkg::ACCEL_OFFSET_Y, 16'hffff);
    host.wr16(scu_pkg::MAG_HARD_IRON_X, 16'hfff6);
    host.wr16(scu_pkg::MAG_SOFT_IRON_X, 16'h7fff);
    rchk(scu_pkg::GYRO_OFFSET_X, 16'hfff6);
    rchk(scu_pkg::ACCEL_OFFSET_X, 16'hfff4);
    rchk(scu_pkg::ACCEL_OFFSET_Y, 16'h3fff);
    rchk(scu_pkg::MAG_HARD_IRON_X, 16'hfff6);
    rchk(scu_pkg::MAG_SOFT_IRON_X, 16'h7fff);
    s.gyro = {16'h7ff0, 16'h0064, 16'h0064};
    s.accel = {16'h0064, 16'h0064, 16'h0064};
    s.mag = {16'h0032, 16'h0032, 16'h0032};
    send(s);
    chk("gyro x", 32'(result_o.gyro[0]), 32'h5a);
    chk("gyro z", 32'(result_o.gyro[2]), 32'h7fff);
    chk("accel x", 32'(result_o.accel[0]), 32'h58);
    chk("accel y", 32'(result_o.accel[1]), 32'h63);
    chk("mag x", 32'(result_o.mag[0]), 32'h50);
    chk("mag y", 32'(result_o.mag[1]), 32'h0);
    // range, decimation, point-of-percussion, then bias null and settle
    host.wr16(scu_pkg::SENSOR_FILTER_RANGE, 16'h0104);
    host.wr16(scu_pkg::SAMPLE_PERIOD_CTRL, 16'h1001);
    host.wr16(scu_pkg::MISC_CONTROL, 16'h0040);
    chk("range", 32'(gyro_range_o), 32'h1);
    chk("taps", 32'(filter_taps_o), 32'h4);
    chk("code", 32'(decim_code_o), 32'h10);
    chk("factor", decim_factor_o, 32'h10000);
    chk("ext clock", 32'(ext_clock_sel_o), 32'h0);
    chk("pop", 32'(pop_enable_o), 32'h1);
    // The motionless settling time is far shorter than in real use.
    host.wr8(scu_pkg::GLOBAL_COMMAND, 8'h01);
    repeat (20) @(posedge clk_i);
    rchk(scu_pkg::GYRO_OFFSET_X, 16'hffa6);
    rchk(scu_pkg::GYRO_OFFSET_Y, 16'hff9c);
    rchk(scu_pkg::GYRO_OFFSET_Z, 16'h8001);
    host.wr8(scu_pkg::GLOBAL_COMMAND, 8'h08);
    repeat (20) @(posedge clk_i);
    chk("saves", 32'(saves), 32'h2);
    host.wr8(scu_pkg::GLOBAL_COMMAND, 8'h02);
    repeat (20) @(posedge clk_i);
    chk("restores", 32'(restores), 32'h1);
    chk("saves", 32'(saves), 32'h3);
    chk("cleared", 32'(result_o == '0), 32'h1);
    rchk(scu_pkg::GYRO_OFFSET_X, 16'h0000);
    rchk(scu_pkg::ACCEL_OFFSET_X, 16'h0000);
    rchk(scu_pkg::MAG_HARD_IRON_X, 16'hfff6);
    test_done;
  end
endmodule
`default_nettype wire
